/* File: src/tws_pkg.sv */
// Package with constants and types for the two-wire slave transmitter block.
`default_nettype none
package tws_pkg;
  localparam logic [7:0] ST_SLA_R_ACK = 8'hA8;
  localparam logic [7:0] ST_ARB_SLA_R = 8'hB0;
  localparam logic [7:0] ST_DATA_ACK = 8'hB8;
  localparam logic [7:0] ST_DATA_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK = 8'hC8;
  localparam logic [7:0] ST_NO_INFO = 8'hF8;
  localparam logic [7:0] ST_BUS_ERROR = 8'h00;
  localparam logic [7:0] GENERAL_CALL_ADDRESS = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BUFFER = 8'h08;
  localparam logic [7:0] OFS_ADDRESS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam int CTL_JOB_DONE = 7;
  localparam int CTL_ACK_EN = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP = 4;
  localparam int CTL_ARB_LOST = 0;
  localparam int IRQ_JOB = 0;
  localparam int IRQ_BUS_ERR = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_ADDR = 3'b001,
    TWS_ADDR_ACK = 3'b010,
    TWS_WAIT_SW = 3'b011,
    TWS_DATA = 3'b100,
    TWS_DATA_ACK = 3'b101,
    TWS_IGNORE = 3'b110
  } tws_state_e;
  typedef struct packed {
    logic ack_enable;
    logic start_request;
    logic stop_request_bit;
    logic arb_lost;
  } tws_ctl_s;
endpackage : tws_pkg
`default_nettype wire

/* File: src/tws_slave_tx.sv */
// Two-wire slave transmitter with status codes, bus error and AXI4-Lite map.
`default_nettype none
module tws_slave_tx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic start_pending,
  output logic irq
);
  // Pin synchronisers; stage one is read only by stage two.
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_m, scl_s, scl_d} <= 3'b111;
      {sda_m, sda_s, sda_d} <= 3'b111;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
    end
  end
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  tws_pkg::tws_state_e state;
  tws_pkg::tws_ctl_s ctl;
  logic job_done_flag;
  logic [7:0] status_code_reg;
  logic [7:0] byte_buffer;
  logic [7:0] own_slave_address;
  logic general_call_enable;
  logic [7:0] shifter;
  logic [3:0] bit_cnt;
  logic last_byte;
  logic drive_sda;
  logic [1:0] irq_status, irq_mask;

  // Write channel: address and data accepted separately, each held until both are present.
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
  wire aw_now = s_axi_awvalid & s_axi_awready;
  wire w_now = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_hold | aw_now;
  wire have_w = w_hold | w_now;
  wire [7:0] wr_addr = aw_hold ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_hold ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_hold ? w_strb : s_axi_wstrb;
  wire wr_fire = have_aw & have_w & ~s_axi_bvalid;
  wire wr_lane0 = wr_fire & wr_strb[0];
  wire wr_ctl = wr_lane0 & (wr_addr == tws_pkg::OFS_CONTROL);
  wire wr_buf = wr_lane0 & (wr_addr == tws_pkg::OFS_BUFFER);
  wire wr_adr = wr_lane0 & (wr_addr == tws_pkg::OFS_ADDRESS);
  wire wr_ist = wr_lane0 & (wr_addr == tws_pkg::OFS_IRQ_STATUS);
  wire wr_msk = wr_lane0 & (wr_addr == tws_pkg::OFS_IRQ_MASK);
  wire wr_known = (wr_addr == tws_pkg::OFS_CONTROL) |
      (wr_addr == tws_pkg::OFS_STATUS) | (wr_addr == tws_pkg::OFS_BUFFER) |
      (wr_addr == tws_pkg::OFS_ADDRESS) |
      (wr_addr == tws_pkg::OFS_IRQ_STATUS) |
      (wr_addr == tws_pkg::OFS_IRQ_MASK);
  // Writing one to the job done bit clears it and releases the machine.
  wire job_release = wr_ctl & wr_data[tws_pkg::CTL_JOB_DONE];
  wire recover = job_release & wr_data[tws_pkg::CTL_STOP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tws_pkg::RESP_OKAY;
    end else begin
      if (aw_now & ~wr_fire) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_now & ~wr_fire) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data.
  assign s_axi_arready = ~s_axi_rvalid;
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire [7:0] ctl_view = {job_done_flag, ctl.ack_enable, ctl.start_request,
      ctl.stop_request_bit, 3'b000, ctl.arb_lost};
  // Status reads 0xF8 while the flag is clear.
  wire [7:0] status_view = job_done_flag ? status_code_reg
      : tws_pkg::ST_NO_INFO;
  logic [7:0] rd_byte;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (s_axi_araddr)
      tws_pkg::OFS_CONTROL: rd_byte = ctl_view;
      tws_pkg::OFS_STATUS: rd_byte = status_view;
      tws_pkg::OFS_BUFFER: rd_byte = byte_buffer;
      tws_pkg::OFS_ADDRESS: rd_byte = {own_slave_address[7:1],
          general_call_enable};
      tws_pkg::OFS_IRQ_STATUS: rd_byte = {6'h00, irq_status};
      tws_pkg::OFS_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      default: begin
        rd_byte = 8'h00;
        rd_known = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tws_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_known ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Address match on the received byte.
  wire addr_match = ctl.ack_enable &
      ((shifter[7:1] == own_slave_address[7:1]) |
       (general_call_enable &
        (shifter[7:1] == tws_pkg::GENERAL_CALL_ADDRESS[7:1])));
  wire addr_read = shifter[0];
  wire in_frame = (state == tws_pkg::TWS_ADDR) |
      (state == tws_pkg::TWS_ADDR_ACK) | (state == tws_pkg::TWS_DATA) |
      (state == tws_pkg::TWS_DATA_ACK);
  // A START or STOP once bits of a frame are counted breaks the frame.
  wire bus_error = in_frame & (bit_cnt != 4'h0) &
      (start_cond | stop_cond);
  logic job_event;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= tws_pkg::TWS_IDLE;
      ctl <= '0;
      job_done_flag <= 1'b0;
      status_code_reg <= tws_pkg::ST_NO_INFO;
      byte_buffer <= 8'h00;
      own_slave_address <= 8'h00;
      general_call_enable <= 1'b0;
      shifter <= 8'h00;
      bit_cnt <= 4'h0;
      last_byte <= 1'b0;
      drive_sda <= 1'b0;
      job_event <= 1'b0;
      start_pending <= 1'b0;
    end else begin
      job_event <= 1'b0;
      if (wr_buf) byte_buffer <= wr_data[7:0];
      if (wr_adr) begin
        own_slave_address <= wr_data[7:0];
        general_call_enable <= wr_data[0];
      end
      if (wr_ctl) begin
        ctl.ack_enable <= wr_data[tws_pkg::CTL_ACK_EN];
        ctl.start_request <= wr_data[tws_pkg::CTL_START];
        ctl.stop_request_bit <= wr_data[tws_pkg::CTL_STOP];
        ctl.arb_lost <= wr_data[tws_pkg::CTL_ARB_LOST];
      end
      if (job_release) job_done_flag <= 1'b0;
      if (bus_error) begin
        state <= tws_pkg::TWS_WAIT_SW;
        drive_sda <= 1'b0;
        status_code_reg <= tws_pkg::ST_BUS_ERROR;
        job_done_flag <= 1'b1;
        job_event <= 1'b1;
      end else begin
        case (state)
          tws_pkg::TWS_IDLE, tws_pkg::TWS_IGNORE: begin
            if (start_cond) begin
              state <= tws_pkg::TWS_ADDR;
              bit_cnt <= 4'h0;
              drive_sda <= 1'b0;
            end
          end
          tws_pkg::TWS_ADDR: begin
            if (start_cond) bit_cnt <= 4'h0;
            else if (stop_cond) state <= tws_pkg::TWS_IDLE;
            else if (scl_rise) begin
              shifter <= {shifter[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == tws_pkg::BITS_PER_BYTE) begin
              if (addr_match && addr_read) begin
                drive_sda <= 1'b1;
                state <= tws_pkg::TWS_ADDR_ACK;
              end else begin
                state <= tws_pkg::TWS_IGNORE;
              end
            end
          end
          tws_pkg::TWS_ADDR_ACK: begin
            if (scl_fall) begin
              drive_sda <= 1'b0;
              state <= tws_pkg::TWS_WAIT_SW;
              bit_cnt <= 4'h0;
              job_done_flag <= 1'b1;
              job_event <= 1'b1;
              status_code_reg <= ctl.arb_lost ? tws_pkg::ST_ARB_SLA_R
                  : tws_pkg::ST_SLA_R_ACK;
              ctl.arb_lost <= 1'b0;
            end
          end
          tws_pkg::TWS_WAIT_SW: begin
            if (recover && status_code_reg == tws_pkg::ST_BUS_ERROR) begin
              ctl.stop_request_bit <= 1'b0;
              state <= tws_pkg::TWS_IDLE;
            end else if (job_release) begin
              if (status_code_reg == tws_pkg::ST_DATA_NACK ||
                  status_code_reg == tws_pkg::ST_LAST_ACK) begin
                state <= tws_pkg::TWS_IGNORE;
                start_pending <= wr_data[tws_pkg::CTL_START];
              end else begin
                shifter <= byte_buffer;
                last_byte <= ~wr_data[tws_pkg::CTL_ACK_EN];
                drive_sda <= ~byte_buffer[7];
                bit_cnt <= 4'h1;
                state <= tws_pkg::TWS_DATA;
              end
            end
          end
          tws_pkg::TWS_DATA: begin
            if (scl_fall) begin
              if (bit_cnt == tws_pkg::BITS_PER_BYTE) begin
                drive_sda <= 1'b0;
                state <= tws_pkg::TWS_DATA_ACK;
              end else begin
                shifter <= {shifter[6:0], 1'b0};
                drive_sda <= ~shifter[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          tws_pkg::TWS_DATA_ACK: begin
            if (scl_rise) begin
              state <= tws_pkg::TWS_WAIT_SW;
              job_done_flag <= 1'b1;
              job_event <= 1'b1;
              bit_cnt <= 4'h0;
              if (sda_s) status_code_reg <= tws_pkg::ST_DATA_NACK;
              else if (last_byte)
                status_code_reg <= tws_pkg::ST_LAST_ACK;
              else status_code_reg <= tws_pkg::ST_DATA_ACK;
            end
          end
          default: state <= tws_pkg::TWS_IDLE;
        endcase
      end
      if (start_pending && state == tws_pkg::TWS_IDLE) start_pending <= 1'b0;
    end
  end

  // The clock is held one cycle past a release, so that the first data bit
  // already stands on the data line before the master can raise the clock.
  // Without it the data line would change while the clock goes high.
  logic release_hold;
  always_ff @(posedge aclk) begin
    if (!aresetn) release_hold <= 1'b0;
    else release_hold <= job_release & job_done_flag;
  end
  // Serial clock is held low while the flag is set.
  wire stretch = ((job_done_flag & (state == tws_pkg::TWS_WAIT_SW)) |
      release_hold) & ~scl_s;
  assign scl_o = 1'b0;
  assign scl_oe_n = ~stretch;
  assign sda_o = 1'b0;
  // Data line floats whenever the machine is idle or recovering; the clock is still stretched after a bus error.
  assign sda_oe_n = ~drive_sda;

  // Sticky interrupt status, set wins over a write-one clear.
  wire [1:0] irq_set = {bus_error, job_event};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 2'b00;
      irq_mask <= 2'b00;
    end else begin
      irq_status <= (irq_status & ~(wr_ist ? wr_data[1:0] : 2'b00)) |
          irq_set;
      if (wr_msk) irq_mask <= wr_data[1:0];
    end
  end
  assign irq = |(irq_status & irq_mask);
endmodule : tws_slave_tx
`default_nettype wire

/* File: sim/tws_slave_tx_sva.sv */
// Port checker for the two-wire slave transmitter.
`default_nettype none
module tws_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("rvalid dropped");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h14 |=> s_axi_rresp == tws_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  a_stretch_release: assert property ($rose(scl_oe_n) |->
    $past(s_axi_bvalid)) else $error("clock released without write");
  a_stretch_start: assert property ($fell(scl_oe_n) |-> !scl_i)
    else $error("stretch began while clock high");
  a_sda_in_low: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("data changed while clock high");
  c_stretch: cover property ($rose(scl_oe_n));
  c_drive: cover property ($fell(sda_oe_n));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp[1]);
endmodule : tws_sva
bind tws_slave_tx tws_sva i_sva (.*);
`default_nettype wire

/* File: sim/tws_bm.sv */
// Bus master model that reads bytes from the slave over two wires.
`default_nettype none
module tws_bm (
  input wire logic aclk,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  output logic scl_i,
  output logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  // Both lines are pulled up, so a released line reads high.
  assign scl_i = m_scl && scl_oe_n;
  assign sda_i = m_sda && sda_oe_n;
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic scl_up;
    m_scl <= 1'b1;
    do @(negedge aclk); while (!scl_i);
    wt(2);
  endtask : scl_up
  task automatic bit_io(input logic b, output logic r);
    m_sda <= b;
    wt(2);
    scl_up();
    r = sda_i;
    wt(2);
    m_scl <= 1'b0;
    wt(2);
  endtask : bit_io
  task automatic start_c;
    m_sda <= 1'b0;
    wt(4);
    m_scl <= 1'b0;
    wt(2);
  endtask : start_c
  task automatic stop_c;
    m_sda <= 1'b0;
    wt(2);
    scl_up();
    wt(2);
    m_sda <= 1'b1;
    wt(4);
  endtask : stop_c
  task automatic byte_out(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, a);
  endtask : byte_out
  task automatic byte_in(output logic [7:0] d, input logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(a, r);
  endtask : byte_in
endmodule : tws_bm
`default_nettype wire

/* File: sim/tws_slave_tx_tb_top.sv */
// Bench for the two-wire slave transmitter.
`default_nettype none
module tws_slave_tx_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] ADDR = 7'h2A;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, start_pending, scl_o, sda_o;
  logic scl_i, sda_i, scl_oe_n, sda_oe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fails = 0, checks_done = 0;
  tws_slave_tx i_tws_slave_tx (.*);
  tws_bm i_tws_bm (.*);
  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r);
    logic ta, tw, tk;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      tk = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) begin
        s_axi_awvalid <= 0;
        s_axi_arvalid <= 0;
      end
      if (tw) s_axi_wvalid <= 0;
    end while (!tk);
    s_axi_bready <= 0;
    s_axi_rready <= 0;
  endtask : axi
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    axi(1, a, d, q, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic [1:0] r;
    axi(0, a, 0, q, r);
  endtask : rd
  task automatic wait_st(input logic [7:0] e);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(tws_pkg::OFS_STATUS, q);
      n++;
    end while (q === 32'hF8 && n < 3000);
    chk("status", {24'h0, e}, q);
  endtask : wait_st
  task automatic t_idle;
    logic [31:0] q;
    logic [1:0] r;
    rd(tws_pkg::OFS_STATUS, q);
    chk("idle status", 32'hF8, q);
    axi(0, 8'h40, 0, q, r);
    chk("read resp", {30'h0, tws_pkg::RESP_SLVERR}, {30'h0, r});
    axi(1, 8'h40, 0, q, r);
    chk("write resp", {30'h0, tws_pkg::RESP_SLVERR}, {30'h0, r});
  endtask : t_idle
  task automatic t_read;
    logic a;
    logic [7:0] d1, d2;
    wr(tws_pkg::OFS_ADDRESS, {24'h0, ADDR, 1'b0});
    wr(tws_pkg::OFS_IRQ_MASK, 32'h3);
    wr(tws_pkg::OFS_CONTROL, 32'h40);
    fork
      begin
        i_tws_bm.start_c();
        i_tws_bm.byte_out({ADDR, 1'b1}, a);
        i_tws_bm.byte_in(d1, 1'b0);
        i_tws_bm.byte_in(d2, 1'b0);
        i_tws_bm.stop_c();
      end
      begin
        wait_st(tws_pkg::ST_SLA_R_ACK);
        chk("irq", 1, {31'h0, irq});
        chk("stretch", 0, {31'h0, scl_oe_n});
        wr(tws_pkg::OFS_BUFFER, 32'hA5);
        wr(tws_pkg::OFS_CONTROL, 32'hC0);
        wait_st(tws_pkg::ST_DATA_ACK);
        wr(tws_pkg::OFS_BUFFER, 32'h3C);
        wr(tws_pkg::OFS_CONTROL, 32'h80);
        wait_st(tws_pkg::ST_LAST_ACK);
        wr(tws_pkg::OFS_IRQ_STATUS, 32'h3);
        chk("irq", 0, {31'h0, irq});
        wr(tws_pkg::OFS_CONTROL, 32'hC0);
      end
    join
    chk("addr ack", 0, {31'h0, a});
    chk("byte", 32'hA5, {24'h0, d1});
    chk("byte", 32'h3C, {24'h0, d2});
  endtask : t_read
  task automatic t_arb;
    logic a;
    logic [7:0] d;
    wr(tws_pkg::OFS_CONTROL, 32'h41);
    fork
      begin
        i_tws_bm.start_c();
        i_tws_bm.byte_out({ADDR, 1'b1}, a);
        i_tws_bm.byte_in(d, 1'b1);
        i_tws_bm.stop_c();
      end
      begin
        wait_st(tws_pkg::ST_ARB_SLA_R);
        wr(tws_pkg::OFS_BUFFER, 32'h81);
        wr(tws_pkg::OFS_CONTROL, 32'hC0);
        wait_st(tws_pkg::ST_DATA_NACK);
        wr(tws_pkg::OFS_CONTROL, 32'hE0);
        chk("start pending", 1, {31'h0, start_pending});
      end
    join
    chk("byte", 32'h81, {24'h0, d});
  endtask : t_arb
  task automatic t_berr;
    logic a;
    logic [31:0] q;
    fork
      begin
        i_tws_bm.start_c();
        repeat (4) i_tws_bm.bit_io(1'b0, a);
        i_tws_bm.stop_c();
      end
      wait_st(tws_pkg::ST_BUS_ERROR);
    join
    rd(tws_pkg::OFS_IRQ_STATUS, q);
    chk("error event", 32'h2, q & 32'h2);
    wr(tws_pkg::OFS_CONTROL, 32'hD0);
    rd(tws_pkg::OFS_CONTROL, q);
    chk("control", 32'h40, q & 32'h70);
    rd(tws_pkg::OFS_STATUS, q);
    chk("status", 32'hF8, q);
    chk("lines", 32'h3, {30'h0, scl_oe_n, sda_oe_n});
    chk("pin drive", 32'h0, {30'h0, scl_o, sda_o});
  endtask : t_berr
  task automatic t_deaf;
    logic a;
    logic [31:0] q;
    wr(tws_pkg::OFS_CONTROL, 32'h00);
    i_tws_bm.start_c();
    i_tws_bm.byte_out({ADDR, 1'b1}, a);
    i_tws_bm.stop_c();
    chk("deaf ack", 1, {31'h0, a});
    rd(tws_pkg::OFS_STATUS, q);
    chk("deaf status", 32'hF8, q);
  endtask : t_deaf
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_idle();
    t_read();
    t_arb();
    t_berr();
    t_deaf();
    report_and_stop();
  end
  initial begin
    #400us;
    fails++;
    report_and_stop();
  end
endmodule : tws_slave_tx_tb_top
`default_nettype wire
